/* File: ptt_pkg.sv */
// Package holding the tick timer register map, field layout and timing constants
package ptt_pkg;
  // Register byte addresses on the core private peripheral bus
  localparam logic [31:0] ADDR_CTRL = 32'he000e010; // tick_control_status_register
  localparam logic [31:0] ADDR_RELOAD = 32'he000e014; // tick_reload_register
  localparam logic [31:0] ADDR_CURRENT = 32'he000e018; // tick_current_value_register
  localparam logic [31:0] ADDR_CALIB = 32'he000e01c; // tick_calibration
  // Control register field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_INT_BIT = 1;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_FLAG_BIT = 16;
  // Calibration register field positions
  localparam int CAL_INEXACT_BIT = 30;
  localparam int CAL_NO_REFERENCE_CLOCK_FLAG_BIT = 31;
  // Counter width and reset values
  localparam int CNT_W = 24;
  localparam logic [23:0] RELOAD_RST = 24'h000000;
  localparam logic [23:0] CURRENT_RST = 24'h000000;
  localparam logic [31:0] CALIB_RST = 32'h00000004;
  // Default interval: 10 ms at a 50 MHz tick clock, minus one tick
  localparam int TEN_MS_US = 10000;
  localparam int CAL_CLK_MHZ = 50;
  localparam logic [23:0] TEN_MS_AT_50MHZ = 24'(CAL_CLK_MHZ * TEN_MS_US - 1);
  // Register access request
  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } ptt_req_s;
endpackage : ptt_pkg

/* File: ptt_ref_tick.sv */
// Half-rate reference tick generator
`timescale 1ns/1ps
module ptt_ref_tick
  import ptt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  output logic refTick
);
  // Toggles every cycle, so it is high on every second core clock edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      refTick <= 1'b0;
    end else begin
      refTick <= ~refTick;
    end
  end
endmodule : ptt_ref_tick

/* File: ptt_timer.sv */
// Periodic 24-bit down-counting tick timer with its register block
// Function
// (RULE1) 24-bit down counter, event on reaching zero
// (RULE2) Tick from CPU clock or half-rate reference
// (RULE3) Source select 1 uses full CPU clock
// (RULE4) Calibration mirrors external calibration setting
// (RULE5) Calibration bits 23:0 reset to 0x4
// (RULE6) Bit 30 inexact, bit 31 no-reference
// (RULE7) Software programs reload before expecting interrupts
// (RULE8) Reload equals interval ticks minus one
// (RULE9) Current value write clears counter first
// (RULE10) Control 0x7 enables count, interrupt, CPU clock
// (RULE11) Default value gives 10 ms at 50 MHz
// (RULE12) Reaching zero reloads bits 23:0 of reload
// (RULE13) Zero flag bit 16 clears on read
// (RULE14) Current reads count; write clears count, flag
// (RULE15) Bit 0 enables counting, bit 1 interrupt
// (RULE16) Disabled counter holds value, no events
// (RULE17) Zero reload keeps counter at zero, silent
`timescale 1ns/1ps
module ptt_timer
  import ptt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire ptt_req_s regReq,
  input wire logic [31:0] calibrationSourceSetting,
  output logic [31:0] regRdata,
  output logic tickIrq
);
  // Control bits
  logic countEnable;
  logic tickInterruptEnable;
  logic tickSourceSelect;
  logic zeroReachedFlag; // Sticky, cleared by reading control
  logic [CNT_W-1:0] tickReload;
  logic [CNT_W-1:0] tickCurrent;
  logic [31:0] tickCalibration; // Follows the configuration block setting
  // Decoded accesses
  logic ctrlWrite;
  logic ctrlRead;
  logic reloadWrite;
  logic currentWrite;
  logic refTick;
  logic tick;
  logic zeroEvent; // Counter stepped from one to zero

  assign ctrlWrite = regReq.wr && (regReq.addr == ADDR_CTRL);
  assign ctrlRead = regReq.rd && (regReq.addr == ADDR_CTRL);
  assign reloadWrite = regReq.wr && (regReq.addr == ADDR_RELOAD);
  assign currentWrite = regReq.wr && (regReq.addr == ADDR_CURRENT);

  // Half-rate reference tick
  ptt_ref_tick i_ptt_ref_tick (
    .core_clk(core_clk),
    .rst(rst),
    .refTick(refTick)
  );

  // Tick select: full CPU clock when source select is 1
  assign tick = tickSourceSelect ? 1'b1 : refTick; // [RULE2] [RULE3]

  // A zero event needs counting on, a tick, and a step down from one
  assign zeroEvent = countEnable && tick && !currentWrite && (tickCurrent == 24'h000001); // [RULE1] [RULE16]

  // Control bits; a write of 0x7 sets all three
  always_ff @(posedge core_clk) begin
    if (rst) begin
      countEnable <= 1'b0;
      tickInterruptEnable <= 1'b0;
      tickSourceSelect <= 1'b0;
    end else if (ctrlWrite) begin
      countEnable <= regReq.wdata[CTRL_ENABLE_BIT]; // [RULE15] [RULE10]
      tickInterruptEnable <= regReq.wdata[CTRL_INT_BIT]; // [RULE15] [RULE10]
      tickSourceSelect <= regReq.wdata[CTRL_SRC_BIT]; // [RULE3] [RULE10]
    end
  end

  // Reload value; software is expected to load it before enabling
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickReload <= RELOAD_RST;
    end else if (reloadWrite) begin
      tickReload <= regReq.wdata[CNT_W-1:0]; // [RULE12]
    end
  end

  // Counter: write clears, zero reloads, otherwise steps down on ticks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickCurrent <= CURRENT_RST;
    end else if (currentWrite) begin
      tickCurrent <= CURRENT_RST; // [RULE9] [RULE14]
    end else if (countEnable && tick) begin
      if (tickCurrent == 24'h000000) begin
        // A zero reload stays at zero and never steps from one again
        tickCurrent <= tickReload; // [RULE12] [RULE17]
      end else begin
        tickCurrent <= tickCurrent - 24'h000001; // [RULE1]
      end
    end
    // Disabled: value held as is [RULE16]
  end

  // Zero flag: a new event wins over the clear by read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      zeroReachedFlag <= 1'b0;
    end else if (zeroEvent) begin
      zeroReachedFlag <= 1'b1; // [RULE13]
    end else if (ctrlRead || currentWrite) begin
      zeroReachedFlag <= 1'b0; // [RULE13] [RULE14]
    end
  end

  // Interrupt pulse, one cycle per zero event while enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickIrq <= 1'b0;
    end else begin
      tickIrq <= zeroEvent && tickInterruptEnable; // [RULE15]
    end
  end

  // Calibration mirrors the configuration block, which should carry the
  // 10 ms at 50 MHz count; reset shows the small fixed default
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickCalibration <= CALIB_RST; // [RULE5] [RULE6]
    end else begin
      tickCalibration <= calibrationSourceSetting; // [RULE4] [RULE11]
    end
  end

  // Read data, registered; unmapped addresses and reserved bits read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdata <= 32'h00000000;
    end else if (regReq.rd) begin
      regRdata <= 32'h00000000;
      case (regReq.addr)
        ADDR_CTRL: begin
          regRdata[CTRL_ENABLE_BIT] <= countEnable;
          regRdata[CTRL_INT_BIT] <= tickInterruptEnable;
          regRdata[CTRL_SRC_BIT] <= tickSourceSelect;
          regRdata[CTRL_FLAG_BIT] <= zeroReachedFlag; // [RULE13]
        end
        ADDR_RELOAD: begin
          regRdata[CNT_W-1:0] <= tickReload;
        end
        ADDR_CURRENT: begin
          regRdata[CNT_W-1:0] <= tickCurrent; // [RULE14]
        end
        ADDR_CALIB: begin
          regRdata[CNT_W-1:0] <= tickCalibration[CNT_W-1:0]; // [RULE5]
          regRdata[CAL_INEXACT_BIT] <= tickCalibration[CAL_INEXACT_BIT]; // [RULE6]
          regRdata[CAL_NO_REFERENCE_CLOCK_FLAG_BIT] <= tickCalibration[CAL_NO_REFERENCE_CLOCK_FLAG_BIT]; // [RULE6]
        end
        default: begin
          regRdata <= 32'h00000000;
        end
      endcase
    end
  end

  // Checks
  property p_reload;
    @(posedge core_clk) disable iff (rst)
    (countEnable && tick && !currentWrite && tickCurrent == 24'h000000) |=> (tickCurrent == $past(tickReload));
  endproperty
  a_reload: assert property (p_reload) else $error("counter did not reload at zero"); // [RULE12]

  property p_decrement;
    @(posedge core_clk) disable iff (rst)
    (countEnable && tick && !currentWrite && tickCurrent != 24'h000000) |=>
      (tickCurrent == $past(tickCurrent) - 24'h000001);
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not step down by one"); // [RULE1]

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    (!countEnable && !currentWrite) |=> $stable(tickCurrent) && !tickIrq;
  endproperty
  a_hold: assert property (p_hold) else $error("disabled counter moved or fired"); // [RULE16]

  property p_clear;
    @(posedge core_clk) disable iff (rst)
    currentWrite |=> (tickCurrent == 24'h000000) && !zeroReachedFlag;
  endproperty
  a_clear: assert property (p_clear) else $error("current write did not clear count and flag"); // [RULE14]

  // A zero event always leaves the flag set, even against a read in the same cycle
  property p_flagRead;
    @(posedge core_clk) disable iff (rst)
    zeroEvent |=> zeroReachedFlag;
  endproperty
  a_flagRead: assert property (p_flagRead) else $error("zero flag not set by event"); // [RULE13]

  // A control read or current write with no event leaves the flag clear
  property p_flagClear;
    @(posedge core_clk) disable iff (rst)
    ((ctrlRead || currentWrite) && !zeroEvent) |=> !zeroReachedFlag;
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("zero flag not cleared by read or write"); // [RULE13]

  property p_irq;
    @(posedge core_clk) disable iff (rst)
    tickIrq == $past(zeroEvent && tickInterruptEnable) || $past(rst);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not tied to zero event and enable"); // [RULE15]

  property p_halfRate;
    @(posedge core_clk) disable iff (rst)
    (!tickSourceSelect && tick) |=> !refTick;
  endproperty
  a_halfRate: assert property (p_halfRate) else $error("reference tick not at half rate"); // [RULE2]

  // A missing half-rate tick is followed by one on the next cycle
  property p_refRise;
    @(posedge core_clk) disable iff (rst)
    (!tickSourceSelect && !tick) |=> tick;
  endproperty
  a_refRise: assert property (p_refRise) else $error("reference tick missed a cycle"); // [RULE2]

  property p_calib;
    @(posedge core_clk) disable iff (rst)
    !$past(rst) |-> (tickCalibration == $past(calibrationSourceSetting));
  endproperty
  a_calib: assert property (p_calib) else $error("calibration does not follow setting"); // [RULE4]

  property p_zeroReload;
    @(posedge core_clk) disable iff (rst)
    (tickReload == 24'h000000 && tickCurrent == 24'h000000 && !reloadWrite) |=> !zeroEvent && tickCurrent == 24'h000000;
  endproperty
  a_zeroReload: assert property (p_zeroReload) else $error("zero reload produced an event"); // [RULE17]
endmodule : ptt_timer

/* File: ptt_timer_tb_top.sv */
// Self-checking testbench for the periodic tick timer register block
`timescale 1ns/1ps
module ptt_timer_tb_top;
  import ptt_pkg::*;
  logic core_clk; // 200 MHz core clock
  logic rst; // Synchronous reset, active high
  ptt_req_s regReq; // Register strobe port
  logic [31:0] calibrationSourceSetting; // Configuration block value
  logic [31:0] regRdata; // Registered read data
  logic tickIrq; // Interrupt pulse
  int numErrors; // Mismatch count
  int checkCount; // Comparison count
  int gap; // Measured interrupt period in cycles
  logic [31:0] held; // Counter snapshot while stopped

  ptt_timer i_ptt_timer (
    .core_clk(core_clk),
    .rst(rst),
    .regReq(regReq),
    .calibrationSourceSetting(calibrationSourceSetting),
    .regRdata(regRdata),
    .tickIrq(tickIrq)
  );

  // Free-running clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic wrapUp();
    if (numErrors == 0 && checkCount > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrapUp

  // Compare a 32-bit register value
  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      numErrors++;
    end
  endtask : cmp32

  // Compare a measured count
  task automatic cmpInt(input string what, input int exp, input int got);
    checkCount++;
    if (got != exp) begin
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
      numErrors++;
    end
  endtask : cmpInt

  // One-cycle write strobe, driven on the falling edge
  task automatic regWrite(input logic [31:0] addr, input logic [31:0] data);
    @(negedge core_clk);
    regReq.addr = addr;
    regReq.wdata = data;
    regReq.wr = 1'b1;
    @(negedge core_clk);
    regReq.wr = 1'b0;
  endtask : regWrite

  // Read strobe, then sample once the registered data has settled
  task automatic checkReg(input string what, input logic [31:0] addr, input logic [31:0] exp);
    @(negedge core_clk);
    regReq.addr = addr;
    regReq.rd = 1'b1;
    @(negedge core_clk);
    regReq.rd = 1'b0;
    @(negedge core_clk);
    cmp32(what, exp, regRdata);
  endtask : checkReg

  // Bounded wait for the interrupt pulse; a hang ends the run
  task automatic waitIrq(output int n);
    n = 0;
    while (tickIrq !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 400) begin
        $display("mismatch tickIrq expected 1 seen 0");
        numErrors++;
        wrapUp();
      end
    end
  endtask : waitIrq

  // Cycles between two successive pulses; the first gap after a mode change
  // may be short, so it is skipped; a stuck level gives 1
  task automatic measure(output int g);
    waitIrq(g);
    @(negedge core_clk);
    waitIrq(g);
    @(negedge core_clk);
    waitIrq(g);
    g = g + 1;
  endtask : measure

  // No interrupt may appear for the given number of cycles
  task automatic quiet(input int cycles);
    repeat (cycles) begin
      @(negedge core_clk);
      cmp32("tickIrq", 32'h0, {31'h0, tickIrq});
    end
  endtask : quiet

  // Main sequence
  initial begin
    regReq = '0;
    rst = 1'b1;
    calibrationSourceSetting = CALIB_RST;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    // Reset values and unmapped space
    checkReg("ctrl", ADDR_CTRL, 32'h0);
    checkReg("reload", ADDR_RELOAD, 32'h0);
    checkReg("current", ADDR_CURRENT, 32'h0);
    checkReg("calib", ADDR_CALIB, 32'h4);
    checkReg("unmapped", 32'he000e020, 32'h0);
    // Calibration mirrors the configuration value and ignores writes
    calibrationSourceSetting = {2'b11, 6'h00, TEN_MS_AT_50MHZ};
    checkReg("calib", ADDR_CALIB, 32'hc007a11f);
    regWrite(ADDR_CALIB, 32'h0);
    checkReg("calib", ADDR_CALIB, 32'hc007a11f);
    // Zero reload stays silent
    regWrite(ADDR_RELOAD, 32'h0);
    regWrite(ADDR_CURRENT, 32'h0);
    regWrite(ADDR_CTRL, 32'h7);
    quiet(40);
    checkReg("current", ADDR_CURRENT, 32'h0);
    // Full-rate period is reload plus one cycles
    regWrite(ADDR_RELOAD, 32'h4);
    checkReg("reload", ADDR_RELOAD, 32'h4);
    measure(gap);
    cmpInt("period full", 5, gap);
    // Half-rate source doubles the period, then back to full rate
    regWrite(ADDR_CTRL, 32'h3);
    measure(gap);
    cmpInt("period half", 10, gap);
    regWrite(ADDR_CTRL, 32'h7);
    measure(gap);
    cmpInt("period full", 5, gap);
    // Interrupt disabled: counting goes on, flag still set
    regWrite(ADDR_CTRL, 32'h5);
    quiet(30);
    regWrite(ADDR_CTRL, 32'h4);
    checkReg("ctrl flag", ADDR_CTRL, 32'h00010004);
    checkReg("ctrl clear", ADDR_CTRL, 32'h4);
    // Stopped counter holds its value and raises nothing
    @(negedge core_clk);
    regReq.addr = ADDR_CURRENT;
    regReq.rd = 1'b1;
    @(negedge core_clk);
    regReq.rd = 1'b0;
    @(negedge core_clk);
    held = regRdata;
    quiet(20);
    checkReg("current held", ADDR_CURRENT, held);
    checkReg("ctrl held", ADDR_CTRL, 32'h4);
    // Write to current clears count and flag
    regWrite(ADDR_CTRL, 32'h5);
    repeat (12) @(negedge core_clk);
    regWrite(ADDR_CTRL, 32'h4);
    regWrite(ADDR_CURRENT, 32'hffffffff);
    checkReg("current", ADDR_CURRENT, 32'h0);
    checkReg("ctrl", ADDR_CTRL, 32'h4);
    wrapUp();
  end
endmodule : ptt_timer_tb_top
